// *** design/cedc_consts.vh ***
// Purpose: constants for the cache error detect control block
// Assumes: 32-bit register words on an APB slave port
// Notes:   field positions use the big-endian numbering 32..63;
//          index in the word is 63 minus the printed position
`ifndef CEDC_CONSTS_VH
`define CEDC_CONSTS_VH

// ********************************
// register byte offsets
// ********************************
`define CEDC_OFS_DISABLE 8'h00
`define CEDC_OFS_STATUS 8'h04
`define CEDC_OFS_CONTROL 8'h08
`define CEDC_OFS_REPORT_EN 8'h0C
`define CEDC_OFS_STATE 8'h10
`define CEDC_ADDR_W 8

// ********************************
// field positions (word bit index)
// ********************************
`define CEDC_BIT_REPEAT (63 - 32)
`define CEDC_BIT_TAG_MULTIWAY_HIT_FLAG (63 - 56)
`define CEDC_BIT_TPAR (63 - 59)
`define CEDC_BIT_MBECC (63 - 60)
`define CEDC_BIT_SBECC (63 - 61)
`define CEDC_BIT_DPAR (63 - 62)
`define CEDC_BIT_PARITY_EN 0
`define CEDC_BIT_INJECT 5

// ********************************
// internal class vector order
// ********************************
`define CEDC_CLS_TAG_MULTIWAY_HIT_FLAG 0
`define CEDC_CLS_TPAR 1
`define CEDC_CLS_MBECC 2
`define CEDC_CLS_SBECC 3
`define CEDC_CLS_DPAR 4
`define CEDC_NCLS 5

// ********************************
// reset values
// ********************************
`define CEDC_RST_DISABLE 32'h00000000
`define CEDC_RST_CONTROL 32'h00000000
`define CEDC_RST_REPORT_EN 32'h00000000

`endif

// *** design/cedc_w1c_flags.v ***
// Purpose: bank of sticky flags, set by hardware, cleared by writing one
// Assumes: set and clear are one-cycle strobes on clk
// Notes:   set wins over clear in the same cycle
`timescale 1ns/1ps
`default_nettype none

module cedc_w1c_flags #(
	parameter W = 6
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] set,
	input wire [W-1:0] clr,
	output reg [W-1:0] flags_reg
);

	wire [W-1:0] flags_next;

	// a late event must not vanish under a clear
	assign flags_next = (flags_reg & ~clr) | set;

	always @(posedge clk) begin
		if (rst) begin
			flags_reg <= {W{1'b0}};
		end else begin
			flags_reg <= flags_next;
		end
	end

endmodule // cedc_w1c_flags

`default_nettype wire

// *** design/cedc_apb_port.v ***
// Purpose: APB handshake and address decode for the register file
// Assumes: zero wait states; APB3 pready and pslverr
// Notes:   read data is latched in setup so it comes from a flop
`timescale 1ns/1ps
`default_nettype none
`include "cedc_consts.vh"

module cedc_apb_port (
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`CEDC_ADDR_W-1:0] paddr,
	output wire pready,
	output wire pslverr,
	output wire setup_rd,
	output wire wr_stb,
	output wire [4:0] sel
);

	wire hit;

	assign sel[0] = paddr == `CEDC_OFS_DISABLE;
	assign sel[1] = paddr == `CEDC_OFS_STATUS;
	assign sel[2] = paddr == `CEDC_OFS_CONTROL;
	assign sel[3] = paddr == `CEDC_OFS_REPORT_EN;
	assign sel[4] = paddr == `CEDC_OFS_STATE;
	assign hit = |sel;

	assign pready = 1'b1;
	// unmapped access completes with an error, no side effect
	assign pslverr = psel & penable & ~hit;
	assign setup_rd = psel & ~penable & ~pwrite;
	assign wr_stb = psel & penable & pwrite & hit;

endmodule // cedc_apb_port

`default_nettype wire

// *** design/cedc_top.v ***
// Purpose: error detection gating and status capture for a cache
// Assumes: error pulses and injection level come from logic on clk
// Notes:   threshold counting, address capture, injection itself elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "cedc_consts.vh"

module cedc_top (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`CEDC_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire inject_active,
	input wire err_tag_multiway_hit,
	input wire err_tag_parity,
	input wire err_data_multibit,
	input wire err_data_singlebit,
	input wire err_data_parity,
	output reg machine_check_req,
	output reg [`CEDC_NCLS-1:0] class_detect_reg
);

	// ********************************
	// reset values and class masks
	// ********************************

	// widened to full words so single fields can be picked out
	localparam [31:0] RST_DISABLE = `CEDC_RST_DISABLE;
	localparam [31:0] RST_CONTROL = `CEDC_RST_CONTROL;
	localparam [31:0] RST_REPORT_EN = `CEDC_RST_REPORT_EN;
	localparam [`CEDC_NCLS-1:0] NO_CLS = {`CEDC_NCLS{1'b0}};
	localparam [`CEDC_NCLS-1:0] ALL_CLS = {`CEDC_NCLS{1'b1}};

	// ********************************
	// functions
	// ********************************

	// class vector to register word layout
	function [31:0] cls_to_word;
		input [`CEDC_NCLS-1:0] c;
		begin
			cls_to_word = 32'h00000000;
			cls_to_word[`CEDC_BIT_TAG_MULTIWAY_HIT_FLAG] = c[`CEDC_CLS_TAG_MULTIWAY_HIT_FLAG];
			cls_to_word[`CEDC_BIT_TPAR] = c[`CEDC_CLS_TPAR];
			cls_to_word[`CEDC_BIT_MBECC] = c[`CEDC_CLS_MBECC];
			cls_to_word[`CEDC_BIT_SBECC] = c[`CEDC_CLS_SBECC];
			cls_to_word[`CEDC_BIT_DPAR] = c[`CEDC_CLS_DPAR];
		end
	endfunction

	// register word to class vector
	function [`CEDC_NCLS-1:0] word_to_cls;
		input [31:0] w;
		begin
			word_to_cls = {`CEDC_NCLS{1'b0}};
			word_to_cls[`CEDC_CLS_TAG_MULTIWAY_HIT_FLAG] = w[`CEDC_BIT_TAG_MULTIWAY_HIT_FLAG];
			word_to_cls[`CEDC_CLS_TPAR] = w[`CEDC_BIT_TPAR];
			word_to_cls[`CEDC_CLS_MBECC] = w[`CEDC_BIT_MBECC];
			word_to_cls[`CEDC_CLS_SBECC] = w[`CEDC_BIT_SBECC];
			word_to_cls[`CEDC_CLS_DPAR] = w[`CEDC_BIT_DPAR];
		end
	endfunction

	// ********************************
	// bus port
	// ********************************

	wire setup_rd;
	wire wr_stb;
	wire [4:0] sel;

	cedc_apb_port i_cedc_apb_port (
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pready(pready),
		.pslverr(pslverr),
		.setup_rd(setup_rd),
		.wr_stb(wr_stb),
		.sel(sel)
	);

	// ********************************
	// write strobes
	// ********************************

	// pready is tied high, so each access ends after one cycle
	// writes to the enable view at 0x10 fall on nothing
	wire wr_disable = wr_stb & sel[0];
	wire wr_status = wr_stb & sel[1];
	wire wr_control = wr_stb & sel[2];
	wire wr_report_en = wr_stb & sel[3];

	// ********************************
	// software control registers
	// ********************************

	// only implemented positions are stored, so reserved ones read 0
	reg [`CEDC_NCLS-1:0] check_off_reg;
	reg [`CEDC_NCLS-1:0] check_off_next;
	reg [`CEDC_NCLS-1:0] report_en_reg;
	reg [`CEDC_NCLS-1:0] report_en_next;
	reg cache_parity_enable_reg;
	reg cache_parity_enable_next;

	always @* begin
		check_off_next = check_off_reg;
		report_en_next = report_en_reg;
		cache_parity_enable_next = cache_parity_enable_reg;
		if (wr_disable) begin
			// tag ECC off positions are not stored
			check_off_next = word_to_cls(pwdata);
		end
		if (wr_report_en) begin
			report_en_next = word_to_cls(pwdata);
		end
		if (wr_control) begin
			cache_parity_enable_next = pwdata[`CEDC_BIT_PARITY_EN];
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			check_off_reg <= word_to_cls(RST_DISABLE);
			report_en_reg <= word_to_cls(RST_REPORT_EN);
			cache_parity_enable_reg <= RST_CONTROL[`CEDC_BIT_PARITY_EN];
		end else begin
			check_off_reg <= check_off_next;
			report_en_reg <= report_en_next;
			cache_parity_enable_reg <= cache_parity_enable_next;
		end
	end

	// ********************************
	// detection gating
	// ********************************

	wire off_tag_multiway_hit_flag = check_off_reg[`CEDC_CLS_TAG_MULTIWAY_HIT_FLAG];
	wire off_tpar = check_off_reg[`CEDC_CLS_TPAR];
	wire off_mbecc = check_off_reg[`CEDC_CLS_MBECC];
	wire off_sbecc = check_off_reg[`CEDC_CLS_SBECC];
	wire off_dpar = check_off_reg[`CEDC_CLS_DPAR];
	wire pe = cache_parity_enable_reg;

	// software is expected to set pe and clear off bits before
	// injecting; injection overrides regardless
	reg [`CEDC_NCLS-1:0] nominal_en;
	wire [`CEDC_NCLS-1:0] detect_en;

	// enables as software set them, before the injection override
	always @* begin
		nominal_en = NO_CLS;
		nominal_en[`CEDC_CLS_TAG_MULTIWAY_HIT_FLAG] = ~off_tag_multiway_hit_flag & pe;
		nominal_en[`CEDC_CLS_TPAR] = ~off_tpar;
		nominal_en[`CEDC_CLS_MBECC] = ~off_mbecc;
		nominal_en[`CEDC_CLS_SBECC] = ~off_sbecc;
		// parity only stands in when both ECC checks are off
		nominal_en[`CEDC_CLS_DPAR] =
			~off_dpar & pe & off_mbecc & off_sbecc;
	end

	// injected errors must never be lost to a stale off bit
	assign detect_en = inject_active ? ALL_CLS : nominal_en;

	wire [`CEDC_NCLS-1:0] err_in;
	wire [`CEDC_NCLS-1:0] detected;

	assign err_in[`CEDC_CLS_TAG_MULTIWAY_HIT_FLAG] = err_tag_multiway_hit;
	assign err_in[`CEDC_CLS_TPAR] = err_tag_parity;
	assign err_in[`CEDC_CLS_MBECC] = err_data_multibit;
	assign err_in[`CEDC_CLS_SBECC] = err_data_singlebit;
	assign err_in[`CEDC_CLS_DPAR] = err_data_parity;

	// an error with detection off leaves no trace
	assign detected = err_in & detect_en;

	// ********************************
	// status flags
	// ********************************

	wire [`CEDC_NCLS:0] flags;
	wire [`CEDC_NCLS-1:0] class_flags = flags[`CEDC_NCLS-1:0];
	wire repeat_flag = flags[`CEDC_NCLS];
	wire [`CEDC_NCLS-1:0] clr_cls;
	wire clr_repeat;
	wire repeat_set;
	wire [`CEDC_NCLS-1:0] repeat_cls;
	wire [`CEDC_NCLS:0] flag_set;
	wire [`CEDC_NCLS:0] flag_clr;

	// write 1 clears, write 0
	assign clr_cls = wr_status ? word_to_cls(pwdata) : {`CEDC_NCLS{1'b0}};
	assign clr_repeat = wr_status & pwdata[`CEDC_BIT_REPEAT];

	// second error of a class whose flag is still standing
	// repeat is shared: any class may raise it, one clear drops it
	assign repeat_cls = detected & class_flags;
	assign repeat_set = |repeat_cls;

	// set wins, so an error in the clearing cycle is still seen
	assign flag_set = {repeat_set, detected};
	assign flag_clr = {clr_repeat, clr_cls};

	cedc_w1c_flags #(
		.W(`CEDC_NCLS + 1)
	) i_cedc_w1c_flags (
		.clk(clk),
		.rst(rst),
		.set(flag_set),
		.clr(flag_clr),
		.flags_reg(flags)
	);

	// ********************************
	// reporting toward the core
	// ********************************

	// flags capture every detected class; only the report is gated
	wire report_hit;

	assign report_hit = |(detected & report_en_reg);

	// one-cycle pulse, one cycle after the error pulse
	always @(posedge clk) begin
		if (rst) begin
			machine_check_req <= 1'b0;
			class_detect_reg <= NO_CLS;
		end else begin
			machine_check_req <= report_hit;
			class_detect_reg <= detected;
		end
	end

	// ********************************
	// read back
	// ********************************

	// reserved positions stay 0 in every word
	reg [31:0] rd_word;

	always @* begin
		rd_word = 32'h00000000;
		case (1'b1)
			sel[0]: begin
				rd_word = cls_to_word(check_off_reg);
			end
			sel[1]: begin
				// no tag ECC or config flags exist
				rd_word = cls_to_word(class_flags);
				rd_word[`CEDC_BIT_REPEAT] = repeat_flag;
			end
			sel[2]: begin
				// injection level shown live, it is not stored
				rd_word[`CEDC_BIT_PARITY_EN] = pe;
				rd_word[`CEDC_BIT_INJECT] = inject_active;
			end
			sel[3]: begin
				rd_word = cls_to_word(report_en_reg);
			end
			sel[4]: begin
				// effective enables, handy when debugging gating
				rd_word = cls_to_word(detect_en);
			end
			default: begin
				rd_word = 32'h00000000;
			end
		endcase
	end

	// latched at setup, so a flag set during access shows next read
	always @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (setup_rd) begin
			prdata <= rd_word;
		end
	end

endmodule // cedc_top

`default_nettype wire

// *** bench/cedc_chk_assertions.sv ***
// Purpose: port checker for cedc_top
// Assumes: one clock, synchronous reset
// Notes: mirrors disable and control writes to predict gating
`timescale 1ns/1ps
`default_nettype none
`include "cedc_consts.vh"
module cedc_chk (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`CEDC_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire inject_active,
	input wire [`CEDC_NCLS-1:0] ev,
	input wire machine_check_req,
	input wire [`CEDC_NCLS-1:0] class_detect_reg
);
	logic [31:0] d_reg;
	logic [31:0] r_reg;
	logic pe_reg;
	logic [4:0] x;
	logic [4:0] r5;
	wire wr = psel && penable && pwrite;
	// reserved bits mirrored too; only defined bits are used
	always_ff @(posedge clk) begin
		if (rst) begin
			d_reg <= 32'h0;
			r_reg <= 32'h0;
			pe_reg <= 1'b0;
		end else if (wr && paddr == `CEDC_OFS_DISABLE) begin
			d_reg <= pwdata;
		end else if (wr && paddr == `CEDC_OFS_REPORT_EN) begin
			r_reg <= pwdata;
		end else if (wr && paddr == `CEDC_OFS_CONTROL) begin
			pe_reg <= pwdata[`CEDC_BIT_PARITY_EN];
		end
	end
	assign x = ({pe_reg & ~d_reg[1] & d_reg[3] & d_reg[2], ~d_reg[2],
		~d_reg[3], ~d_reg[4], pe_reg & ~d_reg[7]} | {5{inject_active}}) & ev;
	assign r5 = {r_reg[1], r_reg[2], r_reg[3], r_reg[4], r_reg[7]};
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence rd_s;
		psel && !penable && !pwrite ##1 psel && penable;
	endsequence
	tag_multiway_hit_flag_gate_a: assert property (
		1 |=> class_detect_reg[0] == $past(x[0]))
		else $error("tag_multiway_hit_flag gating wrong");
	tpar_gate_a: assert property (
		1 |=> class_detect_reg[1] == $past(x[1]))
		else $error("tpar gating wrong");
	mbecc_gate_a: assert property (
		1 |=> class_detect_reg[2] == $past(x[2]))
		else $error("mbecc gating wrong");
	sbecc_gate_a: assert property (
		1 |=> class_detect_reg[3] == $past(x[3]))
		else $error("sbecc gating wrong");
	dpar_gate_a: assert property (
		1 |=> class_detect_reg[4] == $past(x[4]))
		else $error("dpar gating wrong");
	inject_all_a: assert property (
		inject_active |=> class_detect_reg == $past(ev))
		else $error("injected error missed");
	mcheck_cause_a: assert property (
		1 |=> machine_check_req == $past(|(x & r5)))
		else $error("report does not match enables");
	slverr_phase_a: assert property (
		pslverr |-> psel && penable)
		else $error("slave error outside access");
	unmapped_rd_a: assert property (
		rd_s ##0 pslverr |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (
		!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved");
endmodule // cedc_chk
bind cedc_top cedc_chk i_cedc_chk (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pslverr(pslverr), .inject_active(inject_active),
	.ev({err_data_parity, err_data_singlebit, err_data_multibit,
	err_tag_parity, err_tag_multiway_hit}),
	.machine_check_req(machine_check_req), .class_detect_reg(class_detect_reg));
`default_nettype wire

// *** bench/cedc_top_tb.sv ***
// Purpose: self-checking bench for cedc_top
// Assumes: APB slave answers through pready
// Notes: all five classes pulsed together per gating case
`timescale 1ns/1ps
`default_nettype none
`include "cedc_consts.vh"
module cedc_top_tb;
	logic clk, rst, psel, penable, pwrite, inj, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, q, s;
	logic [4:0] err, c;
	wire [31:0] prdata;
	wire pready, pslverr, mc;
	wire [4:0] cls;
	int num_errors, num_checks;
	logic [31:0] dtab [0:8] = '{32'h0, 32'h0, 32'hC, 32'hC, 32'h9E, 32'h9E,
		32'h8, 32'h90, 32'h0};
	// bit0 parity enable, bit1 injection; last entry prepares as advised
	logic [1:0] ptab [0:8] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h1, 2'h3, 2'h1, 2'h1,
		2'h3};
	cedc_top i_cedc_top (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.inject_active(inj), .err_tag_multiway_hit(err[0]),
		.err_tag_parity(err[1]), .err_data_multibit(err[2]),
		.err_data_singlebit(err[3]), .err_data_parity(err[4]),
		.machine_check_req(mc), .class_detect_reg(cls));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task stop_test;
		if (num_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk_reg(input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			num_errors++;
			$display("[FAIL] %0t exp %h got %h", $time, x, g);
		end
	endtask
	task chk_pin(input logic [5:0] x, input logic [5:0] g);
		chk_reg({26'h0, x}, {26'h0, g});
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			num_errors++;
			stop_test;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		chk_reg(x, q);
	endtask
	// error inputs are driven on one edge and sampled on the next, outputs looked at 1 ns after that edge
	task pulse(input logic i);
		@(posedge clk);
		err <= 5'h1F;
		inj <= i;
		@(posedge clk);
		err <= 5'h0;
		inj <= 1'b0;
		#1;
	endtask
	function logic [4:0] expc(input logic [31:0] d, input logic [1:0] p);
		expc = {p[0] & ~d[1] & d[3] & d[2], ~d[2], ~d[3], ~d[4], p[0] & ~d[7]};
		if (p[1])
			expc = 5'h1F;
	endfunction
	// class vector to its bits in the status and enable words
	function logic [31:0] cw(input logic [4:0] v);
		cw = {24'h0, v[0], 2'b0, v[1], v[2], v[3], v[4], 1'b0};
	endfunction
	initial begin
		{psel, penable, pwrite, inj, e} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		err = 5'h0;
		rst = 1'b1;
		num_errors = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int k = 0; k < 4; k++)
			rd(8'(4 * k), 32'h0);
		rd(8'h14, 32'h0);
		chk_reg(32'h1, {31'h0, e});
		xfer(1'b1, `CEDC_OFS_DISABLE, 32'hFFFFFFFF);
		rd(`CEDC_OFS_DISABLE, 32'h9E);
		xfer(1'b1, `CEDC_OFS_REPORT_EN, 32'h10);
		for (int i = 0; i < 9; i++) begin
			c = expc(dtab[i], ptab[i]);
			s = cw(c);
			xfer(1'b1, `CEDC_OFS_DISABLE, dtab[i]);
			xfer(1'b1, `CEDC_OFS_CONTROL, {31'h0, ptab[i][0]});
			rd(`CEDC_OFS_CONTROL, {31'h0, ptab[i][0]});
			rd(`CEDC_OFS_STATE, cw(expc(dtab[i], {1'b0, ptab[i][0]})));
			pulse(ptab[i][1]);
			chk_pin({c[1], c}, {mc, cls});
			rd(`CEDC_OFS_STATUS, s);
			pulse(ptab[i][1]);
			s = s | {|c, 31'h0};
			rd(`CEDC_OFS_STATUS, s);
			xfer(1'b1, `CEDC_OFS_STATUS, 32'h0);
			rd(`CEDC_OFS_STATUS, s);
			xfer(1'b1, `CEDC_OFS_STATUS, 32'h10);
			rd(`CEDC_OFS_STATUS, s & ~32'h10);
			xfer(1'b1, `CEDC_OFS_STATUS, 32'hFFFFFFFF);
			rd(`CEDC_OFS_STATUS, 32'h0);
		end
		stop_test;
	end
endmodule // cedc_top_tb
`default_nettype wire
